// ===== dtpwm_pkg.sv
package dtpwm_pkg;

  // Clock and instruction-cycle timing
  localparam int CLK_PERIOD_NS    = 100;
  localparam int TCY_OSC_PERIODS  = 4;
  localparam int TCY_NS           = TCY_OSC_PERIODS * CLK_PERIOD_NS;
  localparam int TCY_CYCLES       = TCY_NS / CLK_PERIOD_NS;
  localparam logic [1:0] QLAST    = 2'(TCY_CYCLES - 1);
  localparam logic [1:0] QSAMP_A  = 2'h1;
  localparam logic [1:0] QSAMP_B  = 2'h3;

  // Register index = {bank, offset}; byte address = index * 4
  localparam logic [2:0] BANK_1   = 3'h1;
  localparam logic [2:0] BANK_2   = 3'h2;
  localparam logic [2:0] BANK_3   = 3'h3;
  localparam logic [2:0] BANK_7   = 3'h7;
  localparam logic [7:0] IDX_TIMER_ONE_COUNT  = {BANK_2, 5'h10};
  localparam logic [7:0] IDX_TIMER_TWO_COUNT  = {BANK_2, 5'h11};
  localparam logic [7:0] IDX_TIMER_ONE_PERIOD = {BANK_2, 5'h14};
  localparam logic [7:0] IDX_TIMER_TWO_PERIOD = {BANK_2, 5'h15};
  localparam logic [7:0] IDX_PWM_ONE_DUTY_LOW   = {BANK_3, 5'h10};
  localparam logic [7:0] IDX_PWM_TWO_DUTY_LOW   = {BANK_3, 5'h11};
  localparam logic [7:0] IDX_PWM_ONE_DUTY_HIGH  = {BANK_3, 5'h12};
  localparam logic [7:0] IDX_PWM_TWO_DUTY_HIGH  = {BANK_3, 5'h13};
  localparam logic [7:0] IDX_TIMER_CONTROL_ONE  = {BANK_3, 5'h16};
  localparam logic [7:0] IDX_TIMER_CONTROL_TWO  = {BANK_3, 5'h17};
  localparam logic [7:0] IDX_PWM_THREE_DUTY_LOW = {BANK_7, 5'h10};
  localparam logic [7:0] IDX_PWM_THREE_DUTY_HIGH = {BANK_7, 5'h11};
  localparam logic [7:0] IDX_TIMER_CONTROL_THREE = {BANK_7, 5'h16};
  localparam logic [7:0] IDX_PERIPHERAL_FLAGS_ONE   = {BANK_1, 5'h16};
  localparam logic [7:0] IDX_PERIPHERAL_ENABLES_ONE = {BANK_1, 5'h17};

  // Field positions
  localparam int TC1_T_ONE_SRC_SEL = 0;
  localparam int TC1_T_TWO_SRC_SEL = 1;
  localparam int TC1_CASCADE_SEL   = 3;
  localparam int TC2_TIMER_ONE_RUN = 0;
  localparam int TC2_TIMER_TWO_RUN = 1;
  localparam int TC2_PWM_ONE_EN    = 4;
  localparam int TC2_PWM_TWO_EN    = 5;
  localparam int TC3_PWM_THREE_EN  = 0;
  localparam int DCL_BASE_SEL      = 5;
  localparam int PF1_TIMER_ONE_FLAG = 4;
  localparam int PF1_TIMER_TWO_FLAG = 5;

  // Writable masks and reset values
  localparam logic [7:0] TC2_WR_MASK  = 8'h3F;
  localparam logic [7:0] TC3_WR_MASK  = 8'h1F;
  localparam logic [7:0] RST_TCON     = 8'h00;
  localparam logic [7:0] RST_PIE      = 8'h00;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [9:0] RST_DUTY     = 10'h000;

endpackage : dtpwm_pkg

// ===== dtpwm_top.sv
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps

// Functional notes
// - Source select set: timer advances on falling edges of shared clock pin.
// - External clock pin is synchronised first, so counting lags the edge.
// - In every mode the pin is sampled twice per instruction cycle.
// - Cascade joins timer two high, timer one low; match clears, sets flag one.
// - In cascade mode timer one's source select drives the whole counter.
// - Internal source advances once per instruction cycle, Fosc over four.
// - Cascade counts only with both runs; only run one counts low byte.
// - Three outputs; one uses timer one, two and three pick either timer.
// - Duty-low bit 5 of channels two, three: clear timer one, set timer two.
// - PWM period is selected period plus one, times one instruction cycle, or one external clock period with source select set.
// - Duty is ten bits: high register, then low register bits 7:6.
// - Duty zero holds the output low for the whole period.
// - High duty equal to period: low one to four quarters at period end.
// - Full high output only when high duty exceeds the period register.
// - Duty writes go to holding latches, copied to active at rollover.
// - Duty reads return the active latches, not the holding ones.
// - PWM enable takes the pin as output; clear returns it to the port.
// - Each timer's flag marks a new period; only software clears it.
// - External clock sampling gives up to half an instruction cycle of jitter.
// - Eight-bit timer counts to period, clears next step, sets its flag.
// - A timer with run clear neither counts nor sets its flag.
module dtpwm_top
  import dtpwm_pkg::*;
#(
  parameter int NUM_CH = 3
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [9:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              sharedExtTimerClk,
  input  wire logic [NUM_CH-1:0] portData,
  input  wire logic [NUM_CH-1:0] portDirInput,
  output logic      [NUM_CH-1:0] pinOut,
  output logic      [NUM_CH-1:0] pinOe
);

  // Control and status storage
  logic [7:0]        timer_control_one_q;
  logic [7:0]        timer_control_two_q;
  logic [7:0]        timer_control_three_q;
  logic [7:0]        peripheral_enables_one_q;
  logic [7:0]        pr1_q;
  logic [7:0]        pr2_q;
  logic [7:0]        timer_one_count_q;
  logic [7:0]        timer_two_count_q;
  logic              flag1_q;
  logic              flag2_q;
  logic [1:0]        qPhase_q;
  logic              extSync1_q;
  logic              extSync2_q;
  logic              extSamp_q;
  logic              ack_q;
  logic [31:0]       dat_q;
  logic [NUM_CH-1:0] pinOut_q;
  logic [NUM_CH-1:0] pinOe_q;
  logic [7:0]        holdHi_q [NUM_CH];
  logic [1:0]        holdLo_q [NUM_CH];
  logic [9:0]        actDuty_q [NUM_CH];
  logic [NUM_CH-1:0] baseSel_q;

  // Decoded controls
  logic              cascadeSel;
  logic              run1;
  logic              run2;
  logic              src1;
  logic              src2;
  logic              tcyEn;
  logic              sampleEn;
  logic              extTick;
  logic              tick1;
  logic              tick2;
  logic              roll1;
  logic              roll2;
  logic              match1;
  logic              match2;
  logic              match16;
  logic [15:0]       cnt16Inc;
  logic [NUM_CH-1:0] pwmEn;
  logic [NUM_CH-1:0] chRoll;
  logic [NUM_CH-1:0] level;

  // Bus decode
  logic              busReq;
  logic              wrEn;
  logic [7:0]        regIdx;
  logic [7:0]        wd;
  logic [7:0]        rdByte;
  logic [NUM_CH-1:0] wrHi;
  logic [NUM_CH-1:0] wrLo;

  assign busReq = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wrEn   = busReq & wb_we_i & wb_sel_i[0];
  assign regIdx = wb_adr_i[9:2];
  assign wd     = wb_dat_i[7:0];
  assign cascadeSel = timer_control_one_q[TC1_CASCADE_SEL];
  assign run1       = timer_control_two_q[TC2_TIMER_ONE_RUN];
  assign run2       = timer_control_two_q[TC2_TIMER_TWO_RUN];
  assign pwmEn      = {timer_control_three_q[TC3_PWM_THREE_EN], timer_control_two_q[TC2_PWM_TWO_EN],
                       timer_control_two_q[TC2_PWM_ONE_EN]};

  // Quarter-cycle phase; instruction cycle ends at the last quarter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      qPhase_q <= 2'h0;
    end else begin
      qPhase_q <= qPhase_q + 2'h1;
    end
  end
  assign tcyEn    = (qPhase_q == QLAST);
  assign sampleEn = (qPhase_q == QSAMP_A) || (qPhase_q == QSAMP_B);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      extSync1_q <= 1'b0;
      extSync2_q <= 1'b0;
    end else begin
      extSync1_q <= sharedExtTimerClk;
      extSync2_q <= extSync1_q;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      extSamp_q <= 1'b0;
    end else if (sampleEn) begin
      extSamp_q <= extSync2_q;
    end
  end
  assign extTick = sampleEn & extSamp_q & ~extSync2_q;
  assign src1  = timer_control_one_q[TC1_T_ONE_SRC_SEL];
  assign src2  = cascadeSel ? src1 : timer_control_one_q[TC1_T_TWO_SRC_SEL];
  assign tick1 = src1 ? extTick : tcyEn;
  assign tick2 = src2 ? extTick : tcyEn;
  // Match and rollover terms
  assign match1   = (timer_one_count_q == pr1_q);
  assign match2   = (timer_two_count_q == pr2_q);
  assign match16  = ({timer_two_count_q, timer_one_count_q} == {pr2_q, pr1_q});
  assign cnt16Inc = {timer_two_count_q, timer_one_count_q} + 16'h0001;
  always_comb begin
    roll1 = 1'b0;
    roll2 = 1'b0;
    if (cascadeSel) begin
      roll1 = run1 & run2 & tick1 & match16;
    end else begin
      roll1 = run1 & tick1 & match1;
      roll2 = run2 & tick2 & match2;
    end
  end

  // Timer counters; a bus write overrides counting
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_one_count_q <= RST_BYTE;
      timer_two_count_q <= RST_BYTE;
    end else begin
      if (cascadeSel) begin
        if (run1 && tick1 && run2) begin
          if (match16) begin
            timer_one_count_q <= RST_BYTE;
            timer_two_count_q <= RST_BYTE;
          end else begin
            timer_one_count_q <= cnt16Inc[7:0];
            timer_two_count_q <= cnt16Inc[15:8];
          end
        end else if (run1 && tick1) begin
          timer_one_count_q <= timer_one_count_q + 8'h01;
        end
      end else begin
        if (run1 && tick1) begin
          timer_one_count_q <= match1 ? RST_BYTE : timer_one_count_q + 8'h01;
        end
        if (run2 && tick2) begin
          timer_two_count_q <= match2 ? RST_BYTE : timer_two_count_q + 8'h01;
        end
      end
      if (wrEn && regIdx == IDX_TIMER_ONE_COUNT) begin
        timer_one_count_q <= wd;
      end
      if (wrEn && regIdx == IDX_TIMER_TWO_COUNT) begin
        timer_two_count_q <= wd;
      end
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag1_q <= 1'b0;
      flag2_q <= 1'b0;
    end else begin
      if (wrEn && regIdx == IDX_PERIPHERAL_FLAGS_ONE) begin
        flag1_q <= (flag1_q & wd[PF1_TIMER_ONE_FLAG]) | roll1; // Zero clears, one keeps
        flag2_q <= (flag2_q & wd[PF1_TIMER_TWO_FLAG]) | roll2;
      end else begin
        flag1_q <= flag1_q | roll1;
        flag2_q <= flag2_q | roll2;
      end
    end
  end

  // Control, period and enable registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_control_one_q <= RST_TCON;
      timer_control_two_q <= RST_TCON;
      timer_control_three_q <= RST_TCON;
      peripheral_enables_one_q  <= RST_PIE;
      pr1_q   <= RST_BYTE;
      pr2_q   <= RST_BYTE;
    end else if (wrEn) begin
      if (regIdx == IDX_TIMER_CONTROL_ONE) begin
        timer_control_one_q <= wd;
      end else if (regIdx == IDX_TIMER_CONTROL_TWO) begin
        timer_control_two_q <= wd & TC2_WR_MASK;
      end else if (regIdx == IDX_TIMER_CONTROL_THREE) begin
        timer_control_three_q <= wd & TC3_WR_MASK;
      end else if (regIdx == IDX_PERIPHERAL_ENABLES_ONE) begin
        peripheral_enables_one_q <= wd;
      end else if (regIdx == IDX_TIMER_ONE_PERIOD) begin
        pr1_q <= wd;
      end else if (regIdx == IDX_TIMER_TWO_PERIOD) begin
        pr2_q <= wd;
      end
    end
  end

  // Duty register write strobes per channel
  always_comb begin
    wrHi = '0;
    wrLo = '0;
    if (wrEn) begin
      if (regIdx == IDX_PWM_ONE_DUTY_HIGH) begin
        wrHi[0] = 1'b1;
      end else if (regIdx == IDX_PWM_TWO_DUTY_HIGH) begin
        wrHi[1] = 1'b1;
      end else if (regIdx == IDX_PWM_THREE_DUTY_HIGH) begin
        wrHi[2] = 1'b1;
      end else if (regIdx == IDX_PWM_ONE_DUTY_LOW) begin
        wrLo[0] = 1'b1;
      end else if (regIdx == IDX_PWM_TWO_DUTY_LOW) begin
        wrLo[1] = 1'b1;
      end else if (regIdx == IDX_PWM_THREE_DUTY_LOW) begin
        wrLo[2] = 1'b1;
      end
    end
  end

  // Per-channel duty latches, compare and pin takeover
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic [7:0] chCnt;
    logic [9:0] fine;
    // channel one fixed to timer one
    if (i == 0) begin : g_fixed
      assign chRoll[i] = roll1;
      assign chCnt     = timer_one_count_q;
    end else begin : g_sel
      assign chRoll[i] = baseSel_q[i] ? roll2 : roll1;
      assign chCnt     = baseSel_q[i] ? timer_two_count_q : timer_one_count_q;
    end
    // period spans count zero to period
    assign fine = {chCnt, qPhase_q};
    // low once fine count reaches duty
    // equal high byte gives short low
    assign level[i] = (actDuty_q[i] > fine);
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        holdHi_q[i] <= RST_BYTE;
        holdLo_q[i] <= 2'h0;
      end else begin
        if (wrHi[i]) begin
          holdHi_q[i] <= wd;
        end
        if (wrLo[i]) begin
          holdLo_q[i] <= wd[7:6];
        end
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        actDuty_q[i] <= RST_DUTY;
      end else if (chRoll[i]) begin
        actDuty_q[i] <= {holdHi_q[i], holdLo_q[i]};
      end
    end

    // Base select bit is live, not double buffered
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        baseSel_q[i] <= 1'b0;
      end else if (wrLo[i] && i != 0) begin
        baseSel_q[i] <= wd[DCL_BASE_SEL];
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pinOut_q[i] <= 1'b0;
        pinOe_q[i]  <= 1'b0;
      end else if (pwmEn[i]) begin
        pinOut_q[i] <= level[i];
        pinOe_q[i]  <= 1'b1;
      end else begin
        pinOut_q[i] <= portData[i];
        pinOe_q[i]  <= ~portDirInput[i];
      end
    end
  end

  always_comb begin
    rdByte = 8'h00;
    if (regIdx == IDX_TIMER_ONE_COUNT) begin
      rdByte = timer_one_count_q;
    end else if (regIdx == IDX_TIMER_TWO_COUNT) begin
      rdByte = timer_two_count_q;
    end else if (regIdx == IDX_TIMER_ONE_PERIOD) begin
      rdByte = pr1_q;
    end else if (regIdx == IDX_TIMER_TWO_PERIOD) begin
      rdByte = pr2_q;
    end else if (regIdx == IDX_PWM_ONE_DUTY_HIGH) begin
      rdByte = actDuty_q[0][9:2];
    end else if (regIdx == IDX_PWM_TWO_DUTY_HIGH) begin
      rdByte = actDuty_q[1][9:2];
    end else if (regIdx == IDX_PWM_THREE_DUTY_HIGH) begin
      rdByte = actDuty_q[2][9:2];
    end else if (regIdx == IDX_PWM_ONE_DUTY_LOW) begin
      rdByte = {actDuty_q[0][1:0], 6'h00};
    end else if (regIdx == IDX_PWM_TWO_DUTY_LOW) begin
      rdByte = {actDuty_q[1][1:0], baseSel_q[1], 5'h00};
    end else if (regIdx == IDX_PWM_THREE_DUTY_LOW) begin
      rdByte = {actDuty_q[2][1:0], baseSel_q[2], 5'h00};
    end else if (regIdx == IDX_TIMER_CONTROL_ONE) begin
      rdByte = timer_control_one_q;
    end else if (regIdx == IDX_TIMER_CONTROL_TWO) begin
      rdByte = timer_control_two_q;
    end else if (regIdx == IDX_TIMER_CONTROL_THREE) begin
      rdByte = timer_control_three_q;
    end else if (regIdx == IDX_PERIPHERAL_ENABLES_ONE) begin
      rdByte = peripheral_enables_one_q;
    end else if (regIdx == IDX_PERIPHERAL_FLAGS_ONE) begin
      rdByte = 8'h00;
      rdByte[PF1_TIMER_ONE_FLAG] = flag1_q;
      rdByte[PF1_TIMER_TWO_FLAG] = flag2_q;
    end
  end

  // Wishbone answer: one wait state, unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= busReq;
      if (busReq && !wb_we_i) begin
        dat_q <= {24'h00_0000, rdByte};
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign pinOut   = pinOut_q;
  assign pinOe    = pinOe_q;

endmodule : dtpwm_top

// ===== dtpwm_top_sva.sv
`timescale 1ns/1ps
module dtpwm_top_sva
  import dtpwm_pkg::*;
#(
  parameter int NUM_CH = 3
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [9:0]        wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              sharedExtTimerClk,
  input wire logic [NUM_CH-1:0] portData,
  input wire logic [NUM_CH-1:0] portDirInput,
  input wire logic [NUM_CH-1:0] pinOut,
  input wire logic [NUM_CH-1:0] pinOe
);
  logic              wrTake;
  logic [NUM_CH-1:0] pwmEn_q;

  assign wrTake = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

  // Shadow of the output enables, taken on the same edge as the register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwmEn_q <= '0;
    end else if (wrTake && wb_adr_i[9:2] == IDX_TIMER_CONTROL_TWO) begin
      pwmEn_q[1:0] <= wb_dat_i[5:4];
    end else if (wrTake && wb_adr_i[9:2] == IDX_TIMER_CONTROL_THREE) begin
      pwmEn_q[2] <= wb_dat_i[0];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Bus answers and read data
  a_ack_one_wait: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_one_pulse: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_has_req: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  a_read_upper_zero: assert property (
    wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000) else $error("upper bits set");
  a_data_holds: assert property (
    !(wb_ack_o && !wb_we_i) |-> $stable(wb_dat_o)) else $error("read data moved");
  // Pin ownership
  a_port_data_pass: assert property (
    $past(rst_n, 2) |-> ((pinOut ^ $past(portData)) & ~$past(pwmEn_q)) == '0)
    else $error("port data not passed");
  a_port_dir_pass: assert property (
    $past(rst_n, 2) |-> ((pinOe ^ ~$past(portDirInput)) & ~$past(pwmEn_q)) == '0)
    else $error("port direction not passed");
  a_pwm_owns_pin: assert property (
    $past(rst_n, 2) |-> (pinOe | ~$past(pwmEn_q)) == '1) else $error("pwm pin not driven");
  a_reset_quiet: assert property (
    !$past(rst_n) |-> !wb_ack_o && pinOe == '0 && pinOut == '0 && wb_dat_o == 32'h0)
    else $error("outputs not quiet after reset");

  c_read_done: cover property (wb_ack_o && !wb_we_i);
  c_write_done: cover property (wb_ack_o && wb_we_i);
  c_pwm_pulse: cover property (pwmEn_q[0] && $rose(pinOut[0]));
endmodule // dtpwm_top_sva

bind dtpwm_top dtpwm_top_sva #(.NUM_CH(NUM_CH)) i_sva (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .sharedExtTimerClk(sharedExtTimerClk), .portData(portData),
  .portDirInput(portDirInput), .pinOut(pinOut), .pinOe(pinOe)
);

// ===== dtpwm_ext_clk.sv
`timescale 1ns/1ps
// Far-side model of the external timer clock pin
module dtpwm_ext_clk #(
  parameter int HALF = 8
) (
  input  wire logic       clk,
  input  wire logic       go,
  output logic            extClk,
  output logic      [7:0] fallCount
);
  int phase;

  // Pin rests high between bursts
  initial begin
    extClk = 1'b1;
    fallCount = 8'h00;
    phase = 0;
  end

  // slow external clock; a stop finishes the low half, no runt pulse
  always @(posedge clk) begin
    phase = (phase + 1) % HALF;
    if (phase == 0 && (go || !extClk)) begin
      extClk <= !extClk;
      fallCount <= fallCount + {7'h00, extClk};
    end
  end
endmodule // dtpwm_ext_clk

// ===== dtpwm_top_bench.sv
`timescale 1ns/1ps
module dtpwm_top_bench
  import dtpwm_pkg::*;
;
  logic        clk, rst_n, cyc, stb, we, extGo;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datI;
  logic [31:0] datO;
  logic        ack, extClk;
  logic [2:0]  portData, portDirInput, pinOut, pinOe;
  logic [7:0]  fallCount, rv, r0, f0;
  int          bad_count, checked, hi, rises;
  logic [7:0]  ri [6] = '{IDX_PERIPHERAL_ENABLES_ONE, IDX_TIMER_CONTROL_THREE, 8'h00,
                          IDX_TIMER_TWO_PERIOD, IDX_TIMER_ONE_PERIOD, IDX_TIMER_CONTROL_TWO};
  logic [7:0]  wv [6] = '{8'hA5, 8'hFE, 8'hFF, 8'h05, 8'h02, 8'h00};
  logic [7:0]  ev [6] = '{8'hA5, 8'h1E, 8'h00, 8'h05, 8'h02, 8'h00};
  logic [7:0]  dh [4] = '{8'h00, 8'h02, 8'h02, 8'h03};
  logic [7:0]  dl [4] = '{8'h00, 8'hC0, 8'h00, 8'h40};
  logic [7:0]  eh [4] = '{8'h00, 8'h2C, 8'h20, 8'h30};
  logic [7:0]  cr [3] = '{8'h03, 8'h01, 8'h02};
  logic [7:0]  ce [3] = '{8'h01, 8'h00, 8'h00};

  dtpwm_top i_dut (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
    .sharedExtTimerClk(extClk), .portData(portData), .portDirInput(portDirInput),
    .pinOut(pinOut), .pinOe(pinOe)
  );
  dtpwm_ext_clk i_ext (.clk(clk), .go(extGo), .extClk(extClk), .fallCount(fallCount));

  // Clock generation
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Bus cycle held until ack, then one idle cycle
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    datI <= {24'h000000, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rv = datO[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // High cycles and rising edges of one pin over 48 cycles
  task automatic meas(input int ch);
    logic p;
    hi = 0;
    rises = 0;
    @(negedge clk);
    p = pinOut[ch];
    repeat (48) begin
      @(negedge clk);
      if (pinOut[ch] === 1'b1) hi++;
      if (pinOut[ch] === 1'b1 && p !== 1'b1) rises++;
      p = pinOut[ch];
    end
    @(posedge clk);
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    complete_run();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 10'h000;
    sel = 4'hF;
    datI = 32'h0;
    portData = 3'h5;
    portDirInput = 3'h0;
    extGo = 1'b0;
    bad_count = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({5'h00, pinOut}, 8'h05);
    chk({5'h00, pinOe}, 8'h07);
    foreach (ri[i]) begin
      bus(1'b0, ri[i], 8'h00);
      chk(rv, 8'h00);
      bus(1'b1, ri[i], wv[i]);
      bus(1'b0, ri[i], 8'h00);
      chk(rv, ev[i]);
    end
    // duty held until period start; whole-byte writes only
    bus(1'b1, IDX_PWM_ONE_DUTY_HIGH, 8'h01);
    bus(1'b0, IDX_PWM_ONE_DUTY_HIGH, 8'h00);
    chk(rv, 8'h00);
    bus(1'b1, IDX_TIMER_CONTROL_TWO, 8'h11);
    repeat (30) @(posedge clk);
    bus(1'b0, IDX_PWM_ONE_DUTY_HIGH, 8'h00);
    chk(rv, 8'h01);
    meas(0);
    chk(8'(hi), 8'h10);
    chk(8'(rises), 8'h04);
    // flag set, kept by a one, cleared by a zero, held off
    bus(1'b0, IDX_PERIPHERAL_FLAGS_ONE, 8'h00);
    chk(rv, 8'h10);
    bus(1'b1, IDX_TIMER_CONTROL_TWO, 8'h10);
    bus(1'b1, IDX_PERIPHERAL_FLAGS_ONE, 8'h30);
    bus(1'b0, IDX_PERIPHERAL_FLAGS_ONE, 8'h00);
    chk(rv, 8'h10);
    bus(1'b1, IDX_PERIPHERAL_FLAGS_ONE, 8'h00);
    bus(1'b0, IDX_TIMER_ONE_COUNT, 8'h00);
    r0 = rv;
    repeat (30) @(posedge clk);
    bus(1'b0, IDX_PERIPHERAL_FLAGS_ONE, 8'h00);
    chk(rv, 8'h00);
    bus(1'b0, IDX_TIMER_ONE_COUNT, 8'h00);
    chk(rv, r0);
    bus(1'b1, IDX_TIMER_CONTROL_TWO, 8'h11);
    foreach (dh[i]) begin
      bus(1'b1, IDX_PWM_ONE_DUTY_HIGH, dh[i]);
      bus(1'b1, IDX_PWM_ONE_DUTY_LOW, dl[i]);
      repeat (30) @(posedge clk);
      bus(1'b0, IDX_PWM_ONE_DUTY_LOW, 8'h00);
      chk(rv, dl[i]);
      meas(0);
      chk(8'(hi), eh[i]);
    end
    portDirInput <= 3'h7;
    bus(1'b1, IDX_PWM_TWO_DUTY_HIGH, 8'h01);
    bus(1'b1, IDX_PWM_TWO_DUTY_LOW, 8'h20);
    bus(1'b1, IDX_PWM_THREE_DUTY_HIGH, 8'h02);
    bus(1'b1, IDX_PWM_THREE_DUTY_LOW, 8'h00);
    bus(1'b1, IDX_TIMER_CONTROL_THREE, 8'h01);
    bus(1'b1, IDX_TIMER_CONTROL_TWO, 8'h33);
    repeat (60) @(posedge clk);
    chk({5'h00, pinOe}, 8'h07);
    meas(1);
    chk(8'(hi), 8'h08);
    chk(8'(rises), 8'h02);
    meas(2);
    chk(8'(hi), 8'h20);
    bus(1'b0, IDX_PWM_TWO_DUTY_LOW, 8'h00);
    chk(rv, 8'h20);
    bus(1'b0, IDX_PERIPHERAL_FLAGS_ONE, 8'h00);
    chk(rv & 8'h30, 8'h30);
    portData <= 3'h2;
    portDirInput <= 3'h4;
    bus(1'b1, IDX_TIMER_CONTROL_TWO, 8'h03);
    bus(1'b1, IDX_TIMER_CONTROL_THREE, 8'h00);
    chk({5'h00, pinOut}, 8'h02);
    chk({5'h00, pinOe}, 8'h03);
    bus(1'b1, IDX_TIMER_ONE_PERIOD, 8'hFF);
    bus(1'b0, IDX_TIMER_ONE_COUNT, 8'h00);
    r0 = rv;
    repeat (397) @(posedge clk);
    bus(1'b0, IDX_TIMER_ONE_COUNT, 8'h00);
    chk(rv - r0, 8'h64);
    // external falling edges, PWM outputs off
    bus(1'b1, IDX_TIMER_CONTROL_ONE, 8'h01);
    bus(1'b0, IDX_TIMER_ONE_COUNT, 8'h00);
    r0 = rv;
    f0 = fallCount;
    extGo <= 1'b1;
    repeat (200) @(posedge clk);
    extGo <= 1'b0;
    repeat (20) @(posedge clk);
    bus(1'b0, IDX_TIMER_ONE_COUNT, 8'h00);
    chk(rv - r0, fallCount - f0);
    // cascaded counter and run bits, PWM outputs off
    bus(1'b1, IDX_TIMER_CONTROL_TWO, 8'h00);
    bus(1'b1, IDX_TIMER_CONTROL_ONE, 8'h0A);
    foreach (cr[i]) begin
      bus(1'b1, IDX_TIMER_ONE_COUNT, 8'hF0);
      bus(1'b1, IDX_TIMER_TWO_COUNT, 8'h00);
      bus(1'b1, IDX_TIMER_CONTROL_TWO, cr[i]);
      repeat (100) @(posedge clk);
      bus(1'b1, IDX_TIMER_CONTROL_TWO, 8'h00);
      bus(1'b0, IDX_TIMER_TWO_COUNT, 8'h00);
      chk(rv, ce[i]);
    end
    // joined period match clears the pair and sets flag one only
    bus(1'b1, IDX_TIMER_ONE_COUNT, 8'hFC);
    bus(1'b1, IDX_TIMER_TWO_COUNT, 8'h05);
    bus(1'b1, IDX_PERIPHERAL_FLAGS_ONE, 8'h00);
    bus(1'b1, IDX_TIMER_CONTROL_TWO, 8'h03);
    repeat (30) @(posedge clk);
    bus(1'b1, IDX_TIMER_CONTROL_TWO, 8'h00);
    bus(1'b0, IDX_TIMER_TWO_COUNT, 8'h00);
    chk(rv, 8'h00);
    bus(1'b0, IDX_PERIPHERAL_FLAGS_ONE, 8'h00);
    chk(rv, 8'h10);
    complete_run();
  end
endmodule // dtpwm_top_bench
